// file: tsqs_pkg.sv
// shared constants and types for the trigger step queue store
package tsqs_pkg;
    localparam int unsigned TSQS_HADDR_W = 32;
    localparam int unsigned TSQS_HDATA_W = 32;
    localparam int unsigned TSQS_DEC_W = 8;
    localparam int unsigned TSQS_PTR_W = 5;
    localparam int unsigned TSQS_WORD_W = 16;
    localparam int unsigned TSQS_BYTE_W = 8;
    localparam int unsigned TSQS_DEPTH = 8;
    localparam int unsigned TSQS_IDX_W = 3;

    // byte offsets on the bus
    localparam logic [7:0] TSQS_OFF_PTR = 8'h00;
    localparam logic [7:0] TSQS_OFF_CTRL = 8'h04;
    localparam logic [7:0] TSQS_OFF_QUEUE = 8'h20;
    localparam logic [7:0] TSQS_OFF_QUEUE_END = 8'h3c;

    // field positions
    localparam int unsigned TSQS_EVEN_LSB = 0;
    localparam int unsigned TSQS_ODD_LSB = 8;
    localparam int unsigned TSQS_CTRL_EN_BIT = 0;
    localparam int unsigned TSQS_CTRL_START_BIT = 1;
    localparam int unsigned TSQS_CTRL_RUN_BIT = 2;

    // reset values
    localparam logic [4:0] TSQS_PTR_RESET = 5'h00;
    localparam logic [1:0] TSQS_CTRL_RESET = 2'h0;

    // ahb encodings
    localparam logic [1:0] TSQS_HTRANS_NONSEQ = 2'h2;
    localparam logic TSQS_HRESP_OKAY = 1'b0;

    // data phase tracking, gray along idle, read wait, read out
    typedef enum logic [1:0] {
        TSQS_DP_NONE = 2'b00,
        TSQS_DP_RDWAIT = 2'b01,
        TSQS_DP_RDOUT = 2'b11,
        TSQS_DP_WRITE = 2'b10
    } tsqs_dphase_t;
endpackage

// file: tsqs_queue_if.sv
// carrier between the register front end and the queue storage
`timescale 1ns/100ps
`default_nettype none
interface tsqs_queue_if;
    import tsqs_pkg::*;
    logic wr_en;
    logic [TSQS_IDX_W-1:0] wr_idx;
    logic [TSQS_WORD_W-1:0] wr_data;
    logic [TSQS_IDX_W-1:0] rd_idx;
    logic [TSQS_WORD_W-1:0] rd_data;
    logic [TSQS_PTR_W-1:0] step_idx;
    logic [TSQS_BYTE_W-1:0] step_byte;

    modport front (
        output wr_en,
        output wr_idx,
        output wr_data,
        output rd_idx,
        input rd_data,
        output step_idx,
        input step_byte
    );
    modport store (
        input wr_en,
        input wr_idx,
        input wr_data,
        input rd_idx,
        output rd_data,
        input step_idx,
        output step_byte
    );
endinterface
`default_nettype wire

// file: tsqs_queue_store.sv
// eight step command queue words, kept across every reset
`timescale 1ns/100ps
`default_nettype none
module tsqs_queue_store (
    input wire logic hclk,
    tsqs_queue_if.store q
);
    import tsqs_pkg::*;

    logic [TSQS_WORD_W-1:0] mem_reg [TSQS_DEPTH];
    logic [TSQS_IDX_W-1:0] step_word;
    logic [TSQS_WORD_W-1:0] step_word_data;

    // no reset branch on purpose: contents survive every reset
    always_ff @(posedge hclk) begin
        if (q.wr_en) begin
            mem_reg[q.wr_idx] <= q.wr_data;
        end
    end

    assign q.rd_data = mem_reg[q.rd_idx];

    // even_step_byte sits low, odd_step_byte high
    assign step_word = q.step_idx[TSQS_IDX_W:1];
    assign step_word_data = mem_reg[step_word];

    always_comb begin
        if (q.step_idx[TSQS_PTR_W-1]) begin
            // beyond sixteen steps there is no storage
            q.step_byte = '0;
        end else if (q.step_idx[0]) begin
            q.step_byte = step_word_data[TSQS_ODD_LSB +: TSQS_BYTE_W];
        end else begin
            q.step_byte = step_word_data[TSQS_EVEN_LSB +: TSQS_BYTE_W];
        end
    end
endmodule
`default_nettype wire

// file: tsqs_top.sv
// ahb-lite register front end of the trigger step queue store
`timescale 1ns/100ps
`default_nettype none
// How it works
// - five-bit pointer names the active step
// - pointer bits thirty-one to five read zero
// - enable and start both set: lock pointer and queue writes
// - queue word x low byte is even_step_byte
// - queue word x high byte is odd_step_byte
// - queue contents survive every reset
module tsqs_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [tsqs_pkg::TSQS_HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [tsqs_pkg::TSQS_HDATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [tsqs_pkg::TSQS_HDATA_W-1:0] hrdata,
    input wire logic engine_ptr_load,
    input wire logic [tsqs_pkg::TSQS_PTR_W-1:0] engine_ptr_value,
    input wire logic engine_stop,
    output logic seq_running,
    output logic [tsqs_pkg::TSQS_PTR_W-1:0] step_ptr,
    output logic [tsqs_pkg::TSQS_BYTE_W-1:0] step_byte
);
    import tsqs_pkg::*;

    // decode helpers used by both the read and the write path
    function automatic logic is_queue(input logic [TSQS_DEC_W-1:0] off);
        is_queue = (off >= TSQS_OFF_QUEUE) && (off <= TSQS_OFF_QUEUE_END)
            && (off[1:0] == 2'b00);
    endfunction

    function automatic logic [TSQS_IDX_W-1:0] queue_index(input logic [TSQS_DEC_W-1:0] off);
        logic [TSQS_DEC_W-1:0] rel;
        rel = off - TSQS_OFF_QUEUE;
        queue_index = rel[TSQS_IDX_W+1:2];
    endfunction

    tsqs_queue_if qif ();

    tsqs_queue_store u_store (
        .hclk(hclk),
        .q(qif)
    );

    tsqs_dphase_t dphase_reg;
    tsqs_dphase_t dphase_next;
    logic [TSQS_DEC_W-1:0] dp_off_reg;
    logic [TSQS_PTR_W-1:0] ptr_reg;
    logic enable_reg;
    logic start_reg;
    logic [TSQS_HDATA_W-1:0] hrdata_reg;
    logic [TSQS_HDATA_W-1:0] rd_mux;
    logic [TSQS_BYTE_W-1:0] step_byte_reg;
    logic addr_valid;
    logic locked;
    logic wr_ptr;
    logic wr_ctrl;
    logic wr_queue;
    logic [TSQS_DEC_W-1:0] addr_off;

    assign addr_off = haddr[TSQS_DEC_W-1:0];

    // a transfer is taken only when the bus is ready
    assign addr_valid = hsel && hready && htrans[1];

    // both flags set means the engine owns the queue
    assign locked = enable_reg && start_reg;
    assign seq_running = locked;

    // data phase sequencing
    always_comb begin
        dphase_next = TSQS_DP_NONE;
        case (dphase_reg)
            TSQS_DP_RDWAIT: begin
                dphase_next = TSQS_DP_RDOUT;
            end
            TSQS_DP_NONE,
            TSQS_DP_RDOUT,
            TSQS_DP_WRITE: begin
                if (addr_valid) begin
                    dphase_next = hwrite ? TSQS_DP_WRITE : TSQS_DP_RDWAIT;
                end else begin
                    dphase_next = TSQS_DP_NONE;
                end
            end
            default: begin
                dphase_next = TSQS_DP_NONE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_reg <= TSQS_DP_NONE;
        end else begin
            dphase_reg <= dphase_next;
        end
    end

    // address of the transfer now in its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_off_reg <= '0;
        end else if (addr_valid && (dphase_reg != TSQS_DP_RDWAIT)) begin
            dp_off_reg <= addr_off;
        end
    end

    // one wait state on reads so a write just before is already stored
    assign hreadyout = (dphase_reg != TSQS_DP_RDWAIT);
    assign hresp = TSQS_HRESP_OKAY;

    // write strobes live in the last cycle of a write data phase
    always_comb begin
        wr_ptr = 1'b0;
        wr_ctrl = 1'b0;
        wr_queue = 1'b0;
        if (dphase_reg == TSQS_DP_WRITE) begin
            wr_ctrl = (dp_off_reg == TSQS_OFF_CTRL);
            // running sequencer: pointer and queue writes vanish
            wr_ptr = (dp_off_reg == TSQS_OFF_PTR) && !locked;
            wr_queue = is_queue(dp_off_reg) && !locked;
        end
    end

    // pointer: software when idle, engine when it advances
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_reg <= TSQS_PTR_RESET;
        end else if (engine_ptr_load) begin
            ptr_reg <= engine_ptr_value;
        end else if (wr_ptr) begin
            ptr_reg <= hwdata[TSQS_PTR_W-1:0];
        end
    end

    assign step_ptr = ptr_reg;

    // enable flag is software only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg <= TSQS_CTRL_RESET[TSQS_CTRL_EN_BIT];
        end else if (wr_ctrl) begin
            enable_reg <= hwdata[TSQS_CTRL_EN_BIT];
        end
    end

    // start is cleared by the engine; a software set in that cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_reg <= TSQS_CTRL_RESET[TSQS_CTRL_START_BIT];
        end else if (wr_ctrl && hwdata[TSQS_CTRL_START_BIT]) begin
            start_reg <= 1'b1;
        end else if (wr_ctrl || engine_stop) begin
            start_reg <= 1'b0;
        end
    end

    // queue storage ports
    assign qif.wr_en = wr_queue;
    assign qif.wr_idx = queue_index(dp_off_reg);
    assign qif.wr_data = hwdata[TSQS_WORD_W-1:0];
    assign qif.rd_idx = queue_index(dp_off_reg);
    assign qif.step_idx = ptr_reg;

    // read mux, unmapped and reserved bits read zero
    always_comb begin
        rd_mux = '0;
        if (dp_off_reg == TSQS_OFF_PTR) begin
            rd_mux[TSQS_PTR_W-1:0] = ptr_reg;
        end else if (dp_off_reg == TSQS_OFF_CTRL) begin
            rd_mux[TSQS_CTRL_EN_BIT] = enable_reg;
            rd_mux[TSQS_CTRL_START_BIT] = start_reg;
            rd_mux[TSQS_CTRL_RUN_BIT] = locked;
        end else if (is_queue(dp_off_reg)) begin
            rd_mux[TSQS_WORD_W-1:0] = qif.rd_data;
        end
    end

    // read data is caught during the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= '0;
        end else if (dphase_reg == TSQS_DP_RDWAIT) begin
            hrdata_reg <= rd_mux;
        end
    end

    assign hrdata = hrdata_reg;

    // active step byte for the engine, one cycle behind the pointer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_byte_reg <= '0;
        end else begin
            step_byte_reg <= qif.step_byte;
        end
    end

    assign step_byte = step_byte_reg;

    // only whole-word transfers are expected; hsize is not checked
    logic unused_hsize;
    assign unused_hsize = ^hsize;
endmodule
`default_nettype wire

// file: tsqs_top_asserts.sv
// port checker for the trigger step queue store
`timescale 1ns/100ps
`default_nettype none
module tsqs_top_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic engine_ptr_load,
    input wire logic [4:0] engine_ptr_value,
    input wire logic seq_running,
    input wire logic [4:0] step_ptr,
    input wire logic [7:0] step_byte
);
    logic dp_reg, dw_reg, wr, rd, pa;
    logic [7:0] da_reg;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // held through the read wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_reg <= 1'b0;
            dw_reg <= 1'b0;
            da_reg <= 8'h00;
        end else if (hready) begin
            dp_reg <= hsel && htrans[1];
            dw_reg <= hwrite;
            da_reg <= haddr[7:0];
        end
    end
    assign wr = dp_reg && dw_reg && hreadyout;
    assign rd = dp_reg && !dw_reg && hreadyout;
    assign pa = da_reg == 8'h00;
    property p_ld; engine_ptr_load |=> step_ptr == $past(engine_ptr_value); endproperty
    a_ld: assert property (p_ld) else $error("pointer load lost");
    property p_sw; wr && pa && !seq_running && !engine_ptr_load
        |=> step_ptr == $past(hwdata[4:0]); endproperty
    a_sw: assert property (p_sw) else $error("pointer write lost");
    property p_lk; wr && pa && seq_running && !engine_ptr_load |=> $stable(step_ptr); endproperty
    a_lk: assert property (p_lk) else $error("locked pointer changed");
    property p_hi; rd && pa |-> hrdata[31:5] == 27'h0; endproperty
    a_hi: assert property (p_hi) else $error("pointer upper bits set");
    property p_qw; rd && da_reg[7:5] == 3'h1 |-> hrdata[31:16] == 16'h0; endproperty
    a_qw: assert property (p_qw) else $error("queue word too wide");
    property p_go; wr && da_reg == 8'h04 && hwdata[1:0] == 2'h3 |=> seq_running; endproperty
    a_go: assert property (p_go) else $error("lock not entered");
    property p_rs; $rose(seq_running) |-> $past(wr && da_reg == 8'h04); endproperty
    a_rs: assert property (p_rs) else $error("lock without control write");
    property p_nb; step_ptr[4] |=> step_byte == 8'h00; endproperty
    a_nb: assert property (p_nb) else $error("byte beyond queue");
    c_lk: cover property (wr && pa && seq_running);
    c_qw: cover property (rd && da_reg[7:5] == 3'h1);
    c_go: cover property ($rose(seq_running));
endmodule
bind tsqs_top tsqs_top_asserts i_tsqs_top_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .engine_ptr_load(engine_ptr_load),
    .engine_ptr_value(engine_ptr_value), .seq_running(seq_running), .step_ptr(step_ptr),
    .step_byte(step_byte));
`default_nettype wire

// file: tsqs_top_tb.sv
// bench for the trigger step queue store
`timescale 1ns/100ps
`default_nettype none
module tsqs_top_tb;
    import tsqs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, rdy, hresp, ld, stp, run;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [4:0] pv, ptr;
    logic [7:0] sb;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    tsqs_top i_tsqs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
        .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata), .engine_ptr_load(ld),
        .engine_ptr_value(pv), .engine_stop(stp), .seq_running(run), .step_ptr(ptr),
        .step_byte(sb));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // entered just after a rising edge; read data left in r
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= TSQS_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        r = hrdata;
    endtask
    function automatic logic [31:0] qw(int i);
        return {16'h0, 8'(8'h81 + 2 * i), 8'(8'h80 + 2 * i)};
    endfunction
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        ld = 1'b0;
        pv = 5'h0;
        stp = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, TSQS_OFF_PTR, 32'h0);
        chk(r, 32'h0);
        bus(1'b1, TSQS_OFF_PTR, 32'hffff_ffff);
        bus(1'b0, TSQS_OFF_PTR, 32'h0);
        chk(r, 32'h1f);
        // ones in the upper half must not stick
        for (int i = 0; i < 8; i++)
            bus(1'b1, TSQS_OFF_QUEUE + 8'(4 * i), qw(i) | 32'hffff_0000);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, TSQS_OFF_QUEUE + 8'(4 * i), 32'h0);
            chk(r, qw(i));
        end
        // one step past the queue end as well
        for (int k = 0; k < 17; k++) begin
            pv <= 5'(k);
            ld <= 1'b1;
            @(posedge hclk);
            ld <= 1'b0;
            @(posedge hclk);
            #1;
            chk({27'h0, ptr}, 32'(k));
            chk({24'h0, sb}, k < 16 ? 32'h80 + k : 32'h0);
            @(posedge hclk);
        end
        $display("test queue done");
        bus(1'b1, TSQS_OFF_CTRL, 32'h3);
        bus(1'b0, TSQS_OFF_CTRL, 32'h0);
        chk(r, 32'h7);
        chk({31'h0, run}, 32'h1);
        bus(1'b1, TSQS_OFF_PTR, 32'h5);
        bus(1'b1, TSQS_OFF_QUEUE + 8'h0c, 32'h1234);
        chk({31'h0, hresp}, 32'h0);
        bus(1'b0, TSQS_OFF_PTR, 32'h0);
        chk(r, 32'h10);
        bus(1'b0, TSQS_OFF_QUEUE + 8'h0c, 32'h0);
        chk(r, qw(3));
        stp <= 1'b1;
        @(posedge hclk);
        stp <= 1'b0;
        bus(1'b1, TSQS_OFF_PTR, 32'h9);
        chk({31'h0, run}, 32'h0);
        bus(1'b0, TSQS_OFF_PTR, 32'h0);
        chk(r, 32'h9);
        // start alone must not lock either
        bus(1'b1, TSQS_OFF_CTRL, 32'h2);
        bus(1'b1, TSQS_OFF_PTR, 32'h3);
        chk({31'h0, run}, 32'h0);
        bus(1'b0, TSQS_OFF_PTR, 32'h0);
        chk(r, 32'h3);
        $display("test lock done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, TSQS_OFF_PTR, 32'h0);
        chk(r, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, TSQS_OFF_QUEUE + 8'(4 * i), 32'h0);
            chk(r, qw(i));
        end
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
